/* cpu_alu_mul_div_shift.v */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "alu_core_defines.vh"

module cpu_alu_mul_div_shift
#(
  parameter DIV_STEPS = 16
)
(
  input  wire        aclk,          // Core clock, 100 MHz
  input  wire        aresetn,       // Synchronous reset, active low
  input  wire [3:0]  s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output reg         s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write byte enables
  input  wire        s_axi_wvalid,  // Write data valid
  output reg         s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [3:0]  s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output reg         s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready,  // Read data ready
  input  wire        op_valid,      // Operation request
  input  wire [3:0]  op_code,       // Operation select
  input  wire        op_byte,       // Byte-sized operation
  input  wire        op_long,       // 32-bit dividend
  input  wire [15:0] op_a,          // First operand / dividend low
  input  wire [15:0] op_b,          // Second operand / divisor / count
  input  wire [15:0] op_hi,         // Dividend high word
  input  wire [15:0] op_old,        // Present destination register value
  input  wire [3:0]  op_dest,       // Destination register index
  input  wire        op_dest_mem,   // Destination is data memory
  output reg         busy,          // Divider iterating, hold requests
  output reg         res_valid,     // One-cycle result pulse
  output reg  [15:0] res_data,      // Result / product low / quotient
  output reg  [15:0] res_hi,        // Product high / remainder
  output reg         res_hi_wr,     // res_hi is to be written too
  output reg  [3:0]  res_dest,      // Destination of res_data
  output reg  [3:0]  res_hi_dest,   // Destination of res_hi
  output reg         res_to_mem,    // Write res_data to memory
  output reg         res_byte,      // Memory write is one byte
  output reg  [15:0] status_register, // Flags
  input  wire        ipl_update,    // Priority level changed
  input  wire [3:0]  cpu_ipl,       // New priority level
  input  wire        user_irq_req,  // User interrupt pending
  output reg         user_irq_take, // User interrupt accepted
  output reg         program_window_enable, // Program window open
  output reg         priority_above_seven   // Priority above 7
);

  localparam [15:0] CTRL_INIT = `CTRL_RESET;
  // Bus handshake state
  reg         aw_got;
  reg         w_got;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  // Combinational datapath results
  reg  [15:0] next_res;
  reg  [15:0] next_hi;
  reg  [15:0] next_flags;
  reg  [15:0] flag_mask;
  reg  [16:0] ma;
  reg  [16:0] mb;
  reg  [15:0] bx;
  reg  [16:0] sum;
  reg  [8:0]  sum_lo;
  reg  [4:0]  sum_nib;
  reg  [15:0] sh_src;
  reg  [15:0] r;
  reg         is_sub;
  wire signed [33:0] prod = $signed(ma) * $signed(mb);
  wire        take      = op_valid && !busy;
  wire        is_div    = (op_code == `OP_DIV_S) || (op_code == `OP_DIV_U);
  wire        div_sgn   = (op_code == `OP_DIV_S);
  wire [31:0] div_num   = op_long ? {op_hi, op_a}
                        : (div_sgn ? {{16{op_a[15]}}, op_a}
                                   : {16'h0000, op_a});
  wire        div_busy;
  wire        div_done;
  wire [15:0] div_q;
  wire [15:0] div_r;
  wire        wr_fire   = aw_got && w_got && !s_axi_bvalid;
  wire        wr_ctrl   = wr_fire && (aw_addr == `ADDR_CORE_CTRL) && w_strb[0];

  // Byte merge into a register destination
  function [15:0] merge;
    input [15:0] old;
    input [15:0] val;
    input        bsel;
    begin
      merge = bsel ? {old[15:8], val[7:0]} : val;
    end
  endfunction

  quotient_engine #(.STEPS(DIV_STEPS)) u_div
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (take && is_div),
    .sgn      (div_sgn),
    .dividend (div_num),
    .divisor  (op_b),
    .busy     (div_busy),
    .done     (div_done),
    .quot     (div_q),
    .rem      (div_r)
  );

  // ALU, shifter and multiplier operand shaping
  always @*
  begin
    is_sub  = (op_code == `OP_SUB);
    bx      = is_sub ? ~op_b : op_b;
    // subtract as add of complement, carry means no borrow
    sum     = {1'b0, op_a} + {1'b0, bx} + {16'h0000, is_sub};
    sum_lo  = {1'b0, op_a[7:0]} + {1'b0, bx[7:0]} + {8'h00, is_sub};
    sum_nib = {1'b0, op_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, is_sub};
    sh_src  = op_a;
    if (op_byte)
      sh_src = (op_code == `OP_ASR) ? {{8{op_a[7]}}, op_a[7:0]}
                                    : {8'h00, op_a[7:0]};
    ma = {1'b0, op_a};
    mb = {1'b0, op_b};
    case (op_code)
      `OP_MUL_SS:
      begin
        ma = {op_a[15], op_a};
        mb = {op_b[15], op_b};
      end
      `OP_MUL_US:
        mb = {op_b[15], op_b};
      `OP_MUL_SLIT:
      begin
        ma = {op_a[15], op_a};
        mb = {12'h000, op_b[4:0]};
      end
      `OP_MUL_ULIT:
        mb = {12'h000, op_b[4:0]};
      `OP_MUL_BB:
      begin
        ma = {9'h000, op_a[7:0]};
        mb = {9'h000, op_b[7:0]};
      end
      default:
        ma = {1'b0, op_a};
    endcase
    next_hi   = 16'h0000;
    flag_mask = 16'h0000;
    case (op_code)
      `OP_ADD, `OP_SUB:
      begin
        r = sum[15:0];
        flag_mask = 16'h010F;
      end
      `OP_AND:
      begin
        r = op_a & op_b;
        flag_mask = 16'h000A;
      end
      `OP_IOR:
      begin
        r = op_a | op_b;
        flag_mask = 16'h000A;
      end
      `OP_XOR:
      begin
        r = op_a ^ op_b;
        flag_mask = 16'h000A;
      end
      `OP_SHL:
      begin
        r = sh_src << op_b[3:0];
        flag_mask = 16'h000A;
      end
      `OP_ASR:
      begin
        r = $signed(sh_src) >>> op_b[3:0];
        flag_mask = 16'h000A;
      end
      `OP_LSR:
      begin
        r = sh_src >> op_b[3:0];
        flag_mask = 16'h000A;
      end
      default:
      begin
        r = prod[15:0];
        next_hi = prod[31:16];
      end
    endcase
    // flags taken at byte or word width
    next_flags = 16'h0000;
    next_flags[`SR_C_BIT]  = op_byte ? sum_lo[8] : sum[16];
    next_flags[`SR_DC_BIT] = op_byte ? sum_nib[4] : sum_lo[8];
    next_flags[`SR_N_BIT]  = op_byte ? r[7] : r[15];
    next_flags[`SR_Z_BIT]  = op_byte ? (r[7:0] == 8'h00) : (r == 16'h0000);
    next_flags[`SR_OV_BIT] = op_byte
      ? ((op_a[7] == bx[7]) && (sum_lo[7] != op_a[7]))
      : ((op_a[15] == bx[15]) && (sum[15] != op_a[15]));
    next_res = r;
  end

  // Writeback; divide results held back until the last step
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy            <= 1'b0;
      res_valid       <= 1'b0;
      res_data        <= 16'h0000;
      res_hi          <= 16'h0000;
      res_hi_wr       <= 1'b0;
      res_dest        <= 4'h0;
      res_hi_dest     <= 4'h0;
      res_to_mem      <= 1'b0;
      res_byte        <= 1'b0;
      status_register <= `SR_RESET;
    end
    else
    begin
      res_valid <= 1'b0;
      // busy from start until the final step lands
      busy <= (take && is_div) || (busy && !div_done);
      // fixed destinations, written only on completion
      if (div_done)
      begin
        res_valid   <= 1'b1;
        res_data    <= div_q;
        res_hi      <= div_r;
        res_hi_wr   <= 1'b1;
        res_dest    <= `QUOT_REG_IDX;
        res_hi_dest <= `REM_REG_IDX;
        res_to_mem  <= 1'b0;
        res_byte    <= 1'b0;
      end
      else if (take && !is_div)
      begin
        res_valid   <= 1'b1;
        res_hi      <= next_hi;
        res_hi_wr   <= op_code[3];
        res_dest    <= op_dest;
        res_hi_dest <= op_dest + 4'h1;
        res_to_mem  <= op_dest_mem;
        res_byte    <= op_byte && !op_code[3];
        // byte result leaves the register high byte alone
        res_data    <= (op_dest_mem || op_code[3])
                       ? next_res : merge(op_old, next_res, op_byte);
        status_register <= (status_register & ~flag_mask)
                           | (next_flags & flag_mask);
      end
    end
  end

  // Core control bits and interrupt gate
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_window_enable <= CTRL_INIT[`CTRL_WINDOW_BIT];
      priority_above_seven  <= CTRL_INIT[`CTRL_PRIO_BIT];
      user_irq_take         <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        program_window_enable <= w_data[`CTRL_WINDOW_BIT];
      // hardware update wins over a software clear
      if (ipl_update)
        priority_above_seven <= (cpu_ipl > `PRIO_LIMIT);
      else if (wr_ctrl && !w_data[`CTRL_PRIO_BIT])
        priority_above_seven <= 1'b0;
      // user interrupts held off above level 7
      user_irq_take <= user_irq_req && !priority_above_seven;
    end
  end

  // AXI4-Lite write channel: address and data in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `ADDR_CORE_CTRL) ? `RESP_OKAY
                                                     : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; status and engine state are read-only
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_CORE_CTRL:
            s_axi_rdata <= {28'h0000000, priority_above_seven,
                            program_window_enable, 2'h0};
          `ADDR_STATUS:
            s_axi_rdata <= {16'h0000, status_register};
          `ADDR_ENGINE:
            s_axi_rdata <= {31'h00000000, busy};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* alu_core_defines.vh */
`ifndef ALU_CORE_DEFINES_VH
`define ALU_CORE_DEFINES_VH

// Register byte addresses on the AXI4-Lite slave
`define ADDR_CORE_CTRL    4'h0
`define ADDR_STATUS       4'h4
`define ADDR_ENGINE       4'h8

// cpu_core_control fields
`define CTRL_PRIO_BIT     3
`define CTRL_WINDOW_BIT   2
`define CTRL_RESET        16'h0000

// status_register fields
`define SR_C_BIT          0
`define SR_Z_BIT          1
`define SR_OV_BIT         2
`define SR_N_BIT          3
`define SR_DC_BIT         8
`define SR_RESET          16'h0000

// Priority threshold above which user interrupts are held off
`define PRIO_LIMIT        4'h7

// Operation codes
`define OP_ADD            4'h0
`define OP_SUB            4'h1
`define OP_AND            4'h2
`define OP_IOR            4'h3
`define OP_XOR            4'h4
`define OP_SHL            4'h5
`define OP_ASR            4'h6
`define OP_LSR            4'h7
`define OP_MUL_SS         4'h8
`define OP_MUL_UU         4'h9
`define OP_MUL_US         4'hA
`define OP_MUL_SLIT       4'hB
`define OP_MUL_ULIT       4'hC
`define OP_MUL_BB         4'hD
`define OP_DIV_S          4'hE
`define OP_DIV_U          4'hF

// Fixed destinations of every divide
`define QUOT_REG_IDX      4'h0
`define REM_REG_IDX       4'h1

// Divide iterations: one per divisor bit
`define DIV_CYCLES        5'h10

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* quotient_engine.v */
`timescale 1ns/100ps
`include "alu_core_defines.vh"

// Iterative restoring divider, one quotient bit per cycle
module quotient_engine
#(
  parameter STEPS = 16
)
(
  input  wire        aclk,     // Core clock
  input  wire        aresetn,  // Synchronous reset, active low
  input  wire        start,    // One-cycle start pulse
  input  wire        sgn,      // Signed operands
  input  wire [31:0] dividend, // Dividend, already extended
  input  wire [15:0] divisor,  // Divisor
  output reg         busy,     // Iterating
  output reg         done,     // One-cycle pulse, results valid
  output reg  [15:0] quot,     // Quotient
  output reg  [15:0] rem       // Remainder
);

  reg  [16:0] part;
  reg  [15:0] shq;
  reg  [15:0] dmag;
  reg  [4:0]  cnt;
  reg         neg_q;
  reg         neg_r;
  wire [31:0] dabs  = (sgn && dividend[31]) ? (~dividend + 32'h00000001)
                                            : dividend;
  wire [15:0] vabs  = (sgn && divisor[15]) ? (~divisor + 16'h0001)
                                           : divisor;
  wire [16:0] trial = {part[15:0], shq[15]};
  wire        fits  = trial >= {1'b0, dmag};
  wire [16:0] diff  = trial - {1'b0, dmag};

  // Magnitudes are divided, signs fixed after the last step so that
  // quot and rem never show a partial value
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy  <= 1'b0;
      done  <= 1'b0;
      part  <= 17'h00000;
      shq   <= 16'h0000;
      dmag  <= 16'h0000;
      cnt   <= 5'h00;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      quot  <= 16'h0000;
      rem   <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy  <= 1'b1;
        part  <= {1'b0, dabs[31:16]};
        shq   <= dabs[15:0];
        dmag  <= vabs;
        cnt   <= STEPS[4:0];
        neg_q <= sgn && (dividend[31] ^ divisor[15]);
        neg_r <= sgn && dividend[31];
      end
      else if (busy)
      begin
        part <= fits ? diff : trial;
        shq  <= {shq[14:0], fits};
        cnt  <= cnt - 5'h01;
        if (cnt == 5'h01)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= neg_q ? (~{shq[14:0], fits} + 16'h0001)
                        : {shq[14:0], fits};
          rem  <= neg_r ? (~(fits ? diff[15:0] : trial[15:0]) + 16'h0001)
                        : (fits ? diff[15:0] : trial[15:0]);
        end
      end
    end
  end

endmodule

/* alu_core_checker_assertions.sv */
`timescale 1ns/100ps
// Port-level checks of the operation port and the priority status
module alu_core_checker
#(
  parameter DIV_STEPS = 16
)
(
  input wire        aclk,                 // Core clock
  input wire        aresetn,              // Sync reset, active low
  input wire        op_valid,             // Request
  input wire [3:0]  op_code,              // Operation
  input wire [3:0]  op_dest,              // Destination index
  input wire        busy,                 // Divider running
  input wire        res_valid,            // Result pulse
  input wire [3:0]  res_dest,             // Result destination
  input wire [3:0]  res_hi_dest,          // High result destination
  input wire        res_hi_wr,            // High result written
  input wire        ipl_update,           // Level change
  input wire [3:0]  cpu_ipl,              // New level
  input wire        user_irq_req,         // Pending interrupt
  input wire        user_irq_take,        // Accepted interrupt
  input wire        priority_above_seven  // Priority status
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A request counts only when the divider is idle
  wire take = op_valid && !busy;

  a_alu_one_cycle: assert property (take && op_code < 4'h8 |=> res_valid)
    else $error("alu result not one cycle after request");
  a_mul_pair_dest: assert property (take && op_code inside {[4'h8:4'hD]}
    |=> res_valid && res_hi_wr && res_hi_dest == $past(op_dest) + 4'h1)
    else $error("product high word misplaced");
  a_div_starts: assert property (take && op_code >= 4'hE |=> busy && !res_valid)
    else $error("divide did not raise busy");
  a_div_span: assert property ($rose(busy) |-> ##[15:18] $fell(busy))
    else $error("divide length out of range");
  a_div_quiet: assert property (busy |-> !res_valid)
    else $error("result while divider busy");
  a_div_dest: assert property ($fell(busy) |-> res_valid && res_hi_wr
    && res_dest == 4'h0 && res_hi_dest == 4'h1)
    else $error("divide results not in fixed registers");
  a_res_cause: assert property (res_valid |-> $fell(busy)
    || ($past(take) && $past(op_code) < 4'hE))
    else $error("result without accepted request");
  a_prio_set: assert property (ipl_update && cpu_ipl > 4'h7
    |=> priority_above_seven)
    else $error("priority bit not set above seven");
  a_prio_clear: assert property (ipl_update && cpu_ipl <= 4'h7
    |=> !priority_above_seven)
    else $error("priority bit not cleared");
  a_irq_block: assert property (priority_above_seven |=> !user_irq_take)
    else $error("user interrupt taken at high priority");
  a_irq_pass: assert property (user_irq_req && !priority_above_seven
    |=> user_irq_take)
    else $error("user interrupt not taken");
endmodule

bind cpu_alu_mul_div_shift alu_core_checker #(.DIV_STEPS(DIV_STEPS)) u_chk
(
  .aclk, .aresetn, .op_valid, .op_code, .op_dest, .busy, .res_valid,
  .res_dest, .res_hi_dest, .res_hi_wr, .ipl_update, .cpu_ipl,
  .user_irq_req, .user_irq_take, .priority_above_seven
);

/* op_sequencer.sv */
`timescale 1ns/100ps
// Stand-in for the decoder: issues one operation, waits for its result
module op_sequencer
(
  input  wire         aclk,        // Core clock
  input  wire         busy,        // Divider running
  input  wire         res_valid,   // Result pulse
  output logic        op_valid,    // Request
  output logic [3:0]  op_code,     // Operation
  output logic        op_byte,     // Byte size
  output logic        op_long,     // Long dividend
  output logic [15:0] op_a,        // First operand
  output logic [15:0] op_b,        // Second operand
  output logic [15:0] op_hi,       // Dividend high word
  output logic [15:0] op_old,      // Old destination value
  output logic [3:0]  op_dest,     // Destination index
  output logic        op_dest_mem  // Destination in memory
);
  // Idle request at time zero
  initial
  begin
    op_valid = 1'b0;
    {op_code, op_byte, op_long, op_dest, op_dest_mem} = 11'h000;
    {op_a, op_b, op_hi, op_old} = 64'h0;
  end

  // Operands are dropped once taken so a late sample reads garbage
  task automatic issue(input [3:0] c, input b8, lg, m, input [15:0] a, b, h,
                       o, input [3:0] d, output int n);
    n = 0;
    @(posedge aclk);
    op_valid <= 1'b1;
    {op_code, op_byte, op_long, op_dest} <= {c, b8, lg, d};
    {op_a, op_b, op_hi, op_old} <= {a, b, h, o};
    op_dest_mem <= m && !(c inside {[4'h5:4'h7]});
    // any divisor and aligned pair come in as plain operands
    @(posedge aclk);
    while (busy)
      @(posedge aclk);
    op_valid <= 1'b0;
    {op_a, op_b, op_hi} <= ~{a, b, h};
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!res_valid && n < 100);
  endtask
endmodule

/* cpu_alu_mul_div_shift_test.sv */
`timescale 1ns/100ps
`include "alu_core_defines.vh"
// Self-checking bench for the arithmetic datapath
module cpu_alu_mul_div_shift_test;
  logic        aclk, aresetn, ipl_update, user_irq_req;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cpu_ipl, op_code;
  logic [3:0]  op_dest, res_dest, res_hi_dest;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, op_valid, op_byte, op_long;
  logic        op_dest_mem, busy, res_valid, res_hi_wr, res_to_mem, res_byte;
  logic        user_irq_take, program_window_enable, priority_above_seven;
  logic [15:0] op_a, op_b, op_hi, op_old, res_data, res_hi, status_register;
  int          n_errors, checks;

  cpu_alu_mul_div_shift #(.DIV_STEPS(16)) dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .op_valid, .op_code, .op_byte, .op_long, .op_a, .op_b,
    .op_hi, .op_old, .op_dest, .op_dest_mem, .busy, .res_valid, .res_data,
    .res_hi, .res_hi_wr, .res_dest, .res_hi_dest, .res_to_mem, .res_byte,
    .status_register, .ipl_update, .cpu_ipl, .user_irq_req, .user_irq_take,
    .program_window_enable, .priority_above_seven
  );
  op_sequencer sq
  (
    .aclk, .busy, .res_valid, .op_valid, .op_code, .op_byte, .op_long,
    .op_a, .op_b, .op_hi, .op_old, .op_dest, .op_dest_mem
  );

  // Free-running core clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Each channel is released at its own handshake edge
  task automatic wr(input [3:0] ad, input [31:0] d, output [1:0] r);
    logic a, w, b;
    {a, w, b} = 3'b110;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {ad, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b)
    begin
      @(posedge aclk);
      if (a && s_axi_awready)
      begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid)
      begin
        b = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input [3:0] ad, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'b11};
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    {s_axi_arvalid, s_axi_rready} <= 2'b00;
  endtask

  task automatic ipl(input [3:0] v);
    @(posedge aclk);
    {ipl_update, cpu_ipl} <= {1'b1, v};
    @(posedge aclk);
    ipl_update <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // Reset values, writable and dead bits, bus errors
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`ADDR_CORE_CTRL, d, r);
    chk("ctrl reset", 32'h0, d);
    wr(`ADDR_CORE_CTRL, 32'hFFFFFFFF, r);
    rd(`ADDR_CORE_CTRL, d, r);
    chk("ctrl bits", 32'h4, d);
    chk("window on", 32'h1, program_window_enable);
    wr(`ADDR_CORE_CTRL, 32'h0, r);
    chk("window off", 32'h0, program_window_enable);
    rd(4'hC, d, r);
    chk("unmapped resp", `RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    wr(`ADDR_STATUS, 32'hFFFF, r);
    chk("status write resp", `RESP_SLVERR, r);
  endtask

  // Priority status set by level, cleared by software or a lower level
  task automatic t_prio;
    logic [31:0] d;
    logic [1:0]  r;
    user_irq_req <= 1'b1;
    ipl(4'h8);
    chk("prio set", 32'h1, priority_above_seven);
    chk("irq held", 32'h0, user_irq_take);
    wr(`ADDR_CORE_CTRL, 32'h8, r);
    rd(`ADDR_CORE_CTRL, d, r);
    chk("prio readback", 32'h8, d);
    wr(`ADDR_CORE_CTRL, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk("prio sw clear", 32'h0, priority_above_seven);
    chk("irq taken", 32'h1, user_irq_take);
    ipl(4'h8);
    ipl(4'h7);
    chk("prio hw clear", 32'h0, priority_above_seven);
    user_irq_req <= 1'b0;
  endtask

  task automatic alu(input [3:0] c, input b8, m, input [15:0] a, b, o,
                     input [31:0] e);
    int n;
    sq.issue(c, b8, 1'b0, m, a, b, 16'h0, o, 4'h2, n);
    chk("result", e, c >= `OP_MUL_SS ? {res_hi, res_data} : {16'h0, res_data});
  endtask

  // Arithmetic, logic, shifts and every multiply mode
  task automatic t_alu;
    alu(`OP_ADD, 0, 0, 16'h7FFF, 16'h0001, 16'h0, 32'h8000);
    chk("add flags", 32'h010C, status_register & 16'h010F);
    alu(`OP_SUB, 0, 0, 16'h0000, 16'h0001, 16'h0, 32'hFFFF);
    chk("borrow flags", 32'h0008, status_register & 16'h010F);
    alu(`OP_SUB, 0, 0, 16'h0005, 16'h0005, 16'h0, 32'h0000);
    chk("equal flags", 32'h0103, status_register & 16'h010F);
    alu(`OP_AND, 0, 0, 16'hA5A5, 16'h0FF0, 16'h0, 32'h05A0);
    alu(`OP_IOR, 0, 0, 16'hA5A5, 16'h0FF0, 16'h0, 32'hAFF5);
    alu(`OP_XOR, 0, 0, 16'hA5A5, 16'h0FF0, 16'h0, 32'hAA55);
    alu(`OP_ADD, 1, 0, 16'h00FF, 16'h0001, 16'h1234, 32'h1200);
    chk("byte flags", 32'h0103, status_register & 16'h010F);
    alu(`OP_ADD, 1, 1, 16'hFF80, 16'h0080, 16'hAAAA, 32'h0000);
    chk("mem byte", 32'h300, {res_to_mem, res_byte, res_data[7:0]});
    chk("byte ovf", 32'h0007, status_register & 16'h010F);
    alu(`OP_SHL, 0, 0, 16'h0003, 16'h000F, 16'h0, 32'h8000);
    alu(`OP_ASR, 0, 0, 16'h8000, 16'h000F, 16'h0, 32'hFFFF);
    alu(`OP_LSR, 0, 0, 16'h8000, 16'h000F, 16'h0, 32'h0001);
    alu(`OP_LSR, 0, 0, 16'h8001, 16'h0001, 16'h0, 32'h4000);
    alu(`OP_MUL_SS, 0, 0, 16'hFFFF, 16'hFFFF, 16'h0, 32'h00000001);
    alu(`OP_MUL_UU, 0, 0, 16'hFFFF, 16'hFFFF, 16'h0, 32'hFFFE0001);
    alu(`OP_MUL_US, 0, 0, 16'hFFFF, 16'hFFFF, 16'h0, 32'hFFFF0001);
    alu(`OP_MUL_SLIT, 0, 0, 16'hFFFE, 16'hFFFF, 16'h0, 32'hFFFFFFC2);
    alu(`OP_MUL_ULIT, 0, 0, 16'hFFFF, 16'hFFE1, 16'h0, 32'h0000FFFF);
    alu(`OP_MUL_BB, 0, 0, 16'h12FF, 16'h34FF, 16'h0, 32'h0000FE01);
  endtask

  task automatic dv(input [3:0] c, input lg, input [15:0] a, b, h,
                    input [31:0] e, output int n);
    sq.issue(c, 1'b0, lg, 1'b0, a, b, h, 16'h0, 4'h5, n);
    chk("quot rem", e, {res_hi, res_data});
    chk("div dest", 32'h10, {res_hi_dest, res_dest});
  endtask

  // Both sizes take equal time; a request while busy is ignored
  task automatic t_div;
    int n1, n2;
    logic [31:0] d;
    logic [1:0]  r;
    fork
      dv(`OP_DIV_S, 1, 16'hFF9C, 16'h0007, 16'hFFFF, 32'hFFFEFFF2, n1);
      begin
        repeat (5) @(posedge aclk);
        sq.op_valid <= 1'b1;
        @(posedge aclk);
        sq.op_valid <= 1'b0;
        rd(`ADDR_ENGINE, d, r);
        chk("busy rd", 32'h1, d);
        rd(`ADDR_STATUS, d, r);
        chk("status rd", 32'h5, d);
      end
    join
    dv(`OP_DIV_S, 0, 16'hFF9C, 16'h0007, 16'hABCD, 32'hFFFEFFF2, n2);
    chk("div cycles", n1, n2);
    dv(`OP_DIV_U, 1, 16'h0000, 16'h0003, 16'h0001, 32'h00015555, n1);
    dv(`OP_DIV_U, 0, 16'h03E8, 16'h0007, 16'h0000, 32'h0006008E, n2);
    chk("udiv cycles", n1, n2);
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end

  // Reset, then the scenarios in turn
  initial
  begin
    {n_errors, checks} = 0;
    {aresetn, ipl_update, user_irq_req, cpu_ipl} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prio();
    t_alu();
    t_div();
    close_out();
  end
endmodule
